// ==== vpd_regs.vh ====
/*
 * Constants for the packet dispatcher: instruction field layout,
 * functional unit codes, fetch geometry and reset values.
 * Assumes every includer works on the single core clock.
 */
// Functional notes
// - Fetch fixed 256-bit packets, eight slots.
// - Chain bit one joins next instruction.
// - Chain bit zero ends execute packet.
// - Execute packet holds at most eight.
// - One to eight execute packets per fetch.
// - Dispatch one execute packet per clock.
// - Fetch next only after all dispatched.
// - Two sides, four units each.
// - Sixteen registers per side, shared locally.
// - One cross read, one cross write.
// - Address units move data, either side.
// - Linear or circular, 5/15-bit offsets.
// - Instructions gated by designated condition registers.
// - Byte, half-word and word access sizes.
// - Only multiply units perform multiplication.
`ifndef VPD_REGS_VH
`define VPD_REGS_VH

// Fetch geometry
`define VPD_FP_W      256
`define VPD_INS_W     32
`define VPD_SLOTS     8
`define VPD_FP_BYTES  32'h0000_0020
`define VPD_RST_ADDR  32'h0000_0000
`define VPD_FIFO_D    16
`define VPD_FIFO_AW   4

// Instruction fields (bit positions)
`define VPD_CHAIN     0
`define VPD_UNIT_HI   3
`define VPD_UNIT_LO   1
`define VPD_XRD       4
`define VPD_XWR       5
`define VPD_CIRC      6
`define VPD_LOFS      7
`define VPD_SZ_HI     9
`define VPD_SZ_LO     8
`define VPD_MUL       10
`define VPD_XSIDE     11
`define VPD_OFS_HI    26
`define VPD_SOFS_HI   16
`define VPD_OFS_LO    12
`define VPD_Z         28
`define VPD_CREG_HI   31
`define VPD_CREG_LO   29

// Unit codes: bit 2 selects side B
`define VPD_U_MUL_A   3'h2
`define VPD_U_ADR_A   3'h3
`define VPD_U_MUL_B   3'h6
`define VPD_U_ADR_B   3'h7

// Condition register count and access sizes
`define VPD_NCOND     5
`define VPD_SZ_BYTE   2'h0
`define VPD_SZ_HALF   2'h1
`define VPD_SZ_WORD   2'h2

`endif

// ==== vpd_dispatch.v ====
/*
 * Fetch-packet FIFO, execute-packet splitter and dispatcher for an
 * eight-unit two-sided core. Assumes program memory answers each fetch
 * request with one packet, and that units and condition flags share
 * the core clock.
 */
`timescale 1ns/1ps
`include "vpd_regs.vh"

module vpd_fifo #(
	parameter W  = 256,
	parameter D  = 16,
	parameter AW = 4
) (
	// Clock and reset
	input  wire          core_clk_i,
	input  wire          reset_n_i,
	// Fill side
	input  wire          in_vld_i,
	input  wire [W-1:0]  in_data_i,
	output wire          in_rdy_o,
	// Drain side
	output wire          out_vld_o,
	output wire [W-1:0]  out_data_o,
	input  wire          out_rdy_i
);
	reg  [W-1:0] mem [0:D-1];   // Packet storage
	reg  [AW-1:0] wp_r;         // Write pointer
	reg  [AW-1:0] rp_r;         // Read pointer
	reg  [AW:0]   cnt_r;        // Words held
	reg  [AW:0]   cnt_nxt;
	reg           rdy_r;        // Registered not-full
	wire          push;
	wire          pop;

	// Push only on room, pop only on data
	assign push       = in_vld_i & rdy_r;
	assign pop        = out_vld_o & out_rdy_i;
	assign in_rdy_o   = rdy_r;
	assign out_vld_o  = (cnt_r != {(AW+1){1'b0}});
	assign out_data_o = mem[rp_r];

	// Occupancy after this cycle
	always @* begin
		cnt_nxt = cnt_r;
		if (push & ~pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop & ~push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	// Storage has no reset; only valid words are read
	always @(posedge core_clk_i) begin
		if (push) begin
			mem[wp_r] <= in_data_i;
		end
	end

	// Pointers and full flag
	always @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			wp_r  <= {AW{1'b0}};
			rp_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
			rdy_r <= 1'b1;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			cnt_r <= cnt_nxt;
			// Registered so the fill side never sees a combinational path
			rdy_r <= (cnt_nxt != D[AW:0]);
		end
	end
endmodule

module vpd_dispatch (
	// Clock and reset
	input  wire          core_clk_i,
	input  wire          reset_n_i,
	// Fetch request to program memory
	output wire          fetch_req_o,
	output wire [31:0]   fetch_addr_o,
	// Fetch packet return
	input  wire          mem_vld_i,
	input  wire [255:0]  mem_data_i,
	output wire          mem_rdy_o,
	// Unit handshake and condition flags
	input  wire          units_rdy_i,
	input  wire [4:0]    cond_nz_i,
	// Per-unit issue
	output wire [7:0]    unit_vld_o,
	output wire [7:0]    unit_exec_o,
	output wire [255:0]  unit_ins_o,
	// Address unit controls, index 0 side A, 1 side B
	output wire [1:0]    adr_circ_o,
	output wire [1:0]    adr_long_o,
	output wire [29:0]   adr_ofs_o,
	output wire [3:0]    adr_size_o,
	output wire [1:0]    adr_xside_o,
	// Packet status
	output wire          pkt_bad_o,
	output wire          pkt_spill_o
);
	// One-hot states
	localparam [2:0] ST_REQ   = 3'h1;
	localparam [2:0] ST_WAIT  = 3'h2;
	localparam [2:0] ST_ISSUE = 3'h4;

	reg  [2:0]   st_r;          // Fetch/dispatch state
	reg  [255:0] pkt_r;         // Current fetch packet
	reg  [2:0]   pos_r;         // First undispatched slot
	reg  [31:0]  next_addr_r;   // Address of next fetch
	reg  [31:0]  addr_r;        // Address on the request port
	reg          req_r;         // Request pulse
	reg  [7:0]   vld_r;         // Unit valid pulses
	reg  [7:0]   exe_r;         // Condition passed
	reg  [255:0] ins_r;         // Routed instructions
	reg  [1:0]   circ_r;        // Circular mode per address unit
	reg  [1:0]   long_r;        // Long offset per address unit
	reg  [29:0]  ofs_r;         // Offsets per address unit
	reg  [3:0]   size_r;        // Access sizes per address unit
	reg  [1:0]   xside_r;       // Data on far side per address unit
	reg  [1:0]   adr_use;       // Address unit busy this packet
	reg          bad_r;         // Rejected packet pulse
	reg          spill_r;       // Chain ran off the packet end

	wire         fq_vld;        // FIFO has a packet
	wire [255:0] fq_data;       // Head of FIFO
	wire         fq_pop;        // Take head into splitter
	wire         fire;          // Execute packet leaves this cycle

	// Split results
	reg  [7:0]   take;          // Slots in this execute packet
	reg          brk;           // Chain already broken
	reg  [7:0]   uvld;          // Units addressed
	reg  [7:0]   uexe;          // Units whose condition holds
	reg  [255:0] uins;          // Instruction per unit
	reg          coll;          // Two slots on one unit
	reg          mulbad;        // Multiply on wrong unit
	reg  [1:0]   xr_seen;       // Cross read used per side
	reg  [1:0]   xw_seen;       // Cross write used per side
	reg          xerr;          // Cross path oversubscribed
	reg  [31:0]  w;             // Slot being examined
	reg  [2:0]   u;             // Its unit
	integer      i, j, k;       // One loop index per process, never shared

	// Unit field of an instruction
	function [2:0] unit_of;
		input [31:0] ins;
		begin
			unit_of = ins[`VPD_UNIT_HI:`VPD_UNIT_LO];
		end
	endfunction

	// Condition test against designated registers
	function cond_ok;
		input [31:0] ins;
		input [4:0]  nz;
		reg   [2:0]  c;
		begin
			c = ins[`VPD_CREG_HI:`VPD_CREG_LO];
			// Field zero and unassigned codes always execute
			cond_ok = 1'b1;
			if (c != 3'h0 && c <= `VPD_NCOND) begin
				cond_ok = ins[`VPD_Z] ? ~nz[c - 3'h1] : nz[c - 3'h1];
			end
		end
	endfunction

	// Offset: short form is zero-extended to fifteen bits
	function [14:0] ofs_of;
		input [31:0] ins;
		begin
			ofs_of = ins[`VPD_LOFS] ? ins[`VPD_OFS_HI:`VPD_OFS_LO] : {10'h000, ins[`VPD_SOFS_HI:`VPD_OFS_LO]};
		end
	endfunction

	// Fetch packet queue between memory and splitter
	vpd_fifo #(
		.W  (`VPD_FP_W),
		.D  (`VPD_FIFO_D),
		.AW (`VPD_FIFO_AW)
	) u_fifo (
		.core_clk_i (core_clk_i),
		.reset_n_i  (reset_n_i),
		.in_vld_i   (mem_vld_i),
		.in_data_i  (mem_data_i),
		.in_rdy_o   (mem_rdy_o),
		.out_vld_o  (fq_vld),
		.out_data_o (fq_data),
		.out_rdy_i  (fq_pop)
	);

	// Splitter stalls while units are busy; no fetch is requested until the packet is done, so the FIFO holds at most one packet
	assign fq_pop = st_r[2'd1] & fq_vld;
	assign fire   = st_r[2'd2] & units_rdy_i;

	// Gather one execute packet from pos_r and route it
	always @* begin
		take    = 8'h00;
		brk     = 1'b0;
		uvld    = 8'h00;
		uexe    = 8'h00;
		uins    = 256'h0;
		coll    = 1'b0;
		mulbad  = 1'b0;
		xr_seen = 2'h0;
		xw_seen = 2'h0;
		xerr    = 1'b0;
		w       = 32'h0;
		u       = 3'h0;
		for (i = 0; i < `VPD_SLOTS; i = i + 1) begin
			w = pkt_r[i*32 +: 32];
			if (i >= pos_r && !brk) begin
				take[i] = 1'b1;
				if (!w[`VPD_CHAIN]) begin
					brk = 1'b1;
				end
			end
			if (take[i]) begin
				u = unit_of(w);
				if (uvld[u]) begin
					coll = 1'b1;
				end
				uvld[u]         = 1'b1;
				uins[u*32 +: 32] = w;
				uexe[u]         = cond_ok(w, cond_nz_i);
				if (w[`VPD_MUL] && u != `VPD_U_MUL_A && u != `VPD_U_MUL_B) begin
					mulbad = 1'b1;
				end
				if (w[`VPD_XRD]) begin
					if (xr_seen[u[2]]) begin
						xerr = 1'b1;
					end
					xr_seen[u[2]] = 1'b1;
				end
				if (w[`VPD_XWR]) begin
					if (xw_seen[u[2]]) begin
						xerr = 1'b1;
					end
					xw_seen[u[2]] = 1'b1;
				end
			end
		end
		// local access unrestricted, only cross path policed
		adr_use = {uvld[`VPD_U_ADR_B], uvld[`VPD_U_ADR_A]};
	end

	// Fetch sequencer
	always @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			st_r        <= ST_REQ;
			pkt_r       <= 256'h0;
			pos_r       <= 3'h0;
			next_addr_r <= `VPD_RST_ADDR;
			addr_r      <= `VPD_RST_ADDR;
			req_r       <= 1'b0;
		end else begin
			req_r <= 1'b0;
			case (st_r)
				ST_REQ: begin
					req_r       <= 1'b1;
					addr_r      <= next_addr_r;
					next_addr_r <= next_addr_r + `VPD_FP_BYTES;
					st_r        <= ST_WAIT;
				end
				ST_WAIT: begin
					if (fq_vld) begin
						pkt_r <= fq_data;
						pos_r <= 3'h0;
						st_r  <= ST_ISSUE;
					end
				end
				ST_ISSUE: begin
					if (fire) begin
						if (take[7]) begin
							st_r <= ST_REQ;
						end else begin
							for (j = 1; j < `VPD_SLOTS; j = j + 1) begin
								if (take[j-1] && !take[j]) begin
									pos_r <= j[2:0];
								end
							end
						end
					end
				end
				default: begin
					st_r <= ST_REQ;
				end
			endcase
		end
	end

	// Issue registers: valid and status are one-cycle pulses
	always @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			vld_r   <= 8'h00;
			exe_r   <= 8'h00;
			ins_r   <= 256'h0;
			circ_r  <= 2'h0;
			long_r  <= 2'h0;
			ofs_r   <= 30'h0;
			size_r  <= 4'h0;
			xside_r <= 2'h0;
			bad_r   <= 1'b0;
			spill_r <= 1'b0;
		end else begin
			vld_r   <= 8'h00;
			exe_r   <= 8'h00;
			bad_r   <= 1'b0;
			spill_r <= 1'b0;
			if (fire) begin
				// last slot still chained means a spanning packet
				spill_r <= take[7] & pkt_r[(`VPD_SLOTS-1)*`VPD_INS_W + `VPD_CHAIN];
				if (coll | mulbad | xerr) begin
					// A rejected packet drives no unit at all
					bad_r <= 1'b1;
				end else begin
					vld_r <= uvld;
					exe_r <= uvld & uexe;
					ins_r <= uins;
					for (k = 0; k < 2; k = k + 1) begin
						if (adr_use[k]) begin
							circ_r[k]          <= uins[(k*4+3)*32 + `VPD_CIRC];
							long_r[k]          <= uins[(k*4+3)*32 + `VPD_LOFS];
							ofs_r[k*15 +: 15]  <= ofs_of(uins[(k*4+3)*32 +: 32]);
							size_r[k*2 +: 2]   <= uins[(k*4+3)*32 + `VPD_SZ_LO +: 2];
							xside_r[k]         <= uins[(k*4+3)*32 + `VPD_XSIDE];
						end
					end
				end
			end
		end
	end

	// Outputs straight from flip-flops
	assign fetch_req_o  = req_r;
	assign fetch_addr_o = addr_r;
	assign unit_vld_o   = vld_r;
	assign unit_exec_o  = exe_r;
	assign unit_ins_o   = ins_r;
	assign adr_circ_o   = circ_r;
	assign adr_long_o   = long_r;
	assign adr_ofs_o    = ofs_r;
	assign adr_size_o   = size_r;
	assign adr_xside_o  = xside_r;
	assign pkt_bad_o    = bad_r;
	assign pkt_spill_o  = spill_r;
endmodule

// ==== vpd_dispatch_assertions.sv ====
/* Checker for the packet dispatcher: fetch and issue timing at the top ports.
   Assumes it is bound to vpd_dispatch on the single core clock. */
`timescale 1ns/1ps
module vpd_chk (
	// Clock and reset
	input wire        core_clk_i,
	input wire        reset_n_i,
	// Fetch link
	input wire        fetch_req_o,
	input wire [31:0] fetch_addr_o,
	input wire        mem_vld_i,
	input wire        mem_rdy_o,
	// Issue side
	input wire        units_rdy_i,
	input wire [7:0]  unit_vld_o,
	input wire [7:0]  unit_exec_o,
	input wire        pkt_bad_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	reg [31:0] nxt_r;  // Address the next request must carry
	reg        seen_r; // First request after reset is not stepped
	always @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			seen_r <= 1'b0;
			nxt_r  <= 32'h0;
		end else if (fetch_req_o) begin
			seen_r <= 1'b1;
			nxt_r  <= fetch_addr_o + 32'h20;
		end
	end
	a_addr_step: assert property (fetch_req_o && seen_r |-> fetch_addr_o == nxt_r)
		else $error("fetch address did not step by one packet");
	a_addr_hold: assert property (!fetch_req_o |-> $stable(fetch_addr_o))
		else $error("fetch address moved without a request");
	a_stall_quiet: assert property (!units_rdy_i |=> unit_vld_o == 8'h0 && !pkt_bad_o)
		else $error("issue while units not ready");
	a_exec_gated: assert property ((unit_exec_o & ~unit_vld_o) == 8'h0)
		else $error("execute without valid");
	a_bad_empty: assert property (pkt_bad_o |-> unit_vld_o == 8'h0)
		else $error("rejected packet reached units");
	a_fetch_apart: assert property (fetch_req_o |-> unit_vld_o == 8'h0 && !pkt_bad_o)
		else $error("fetch during dispatch");
	a_req_space: assert property (fetch_req_o |=> !fetch_req_o [*4])
		else $error("fetch requests too close");
	a_load_gap: assert property (mem_vld_i && mem_rdy_o |=> (unit_vld_o == 8'h0 && !pkt_bad_o) [*2])
		else $error("issue before packet was loaded");
endmodule

// ==== vpd_mem_model.sv ====
/* Program memory model for the dispatcher fetch link.
   Assumes one request outstanding; packet and latency come from the bench. */
`timescale 1ns/1ps
module vpd_mem_model (
	// Clock and reset
	input  wire         clk_i,
	input  wire         rst_n_i,
	// Request side
	input  wire         req_i,
	input  wire [3:0]   lat_i,
	input  wire [255:0] pk_i,
	// Return side
	input  wire         rdy_i,
	output reg          vld_o,
	output reg  [255:0] data_o
);
	reg       pend_r; // Request waiting
	reg [3:0] cnt_r;  // Cycles left
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			vld_o  <= 1'b0;
			pend_r <= 1'b0;
			cnt_r  <= 4'h0;
			data_o <= 256'h0;
		end else if (vld_o) begin
			if (rdy_i) begin
				vld_o  <= 1'b0;
				// Released data changes so stale packets never look valid
				data_o <= ~data_o;
			end
		end else if (req_i) begin
			pend_r <= 1'b1;
			cnt_r  <= lat_i;
		end else if (pend_r) begin
			if (cnt_r == 4'h0) begin
				vld_o  <= 1'b1;
				data_o <= pk_i;
				pend_r <= 1'b0;
			end else begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end
endmodule

// ==== test_vliw_packet_dispatch.sv ====
/* Bench for vpd_dispatch driven through a program memory model.
   Assumes every fetch request is answered with the bench packet. */
`timescale 1ns/1ps
module test_vliw_packet_dispatch;
	reg          clk, rst_n, urdy;
	reg  [4:0]   nz;
	reg  [3:0]   lat;
	reg  [255:0] pk;
	wire         freq, mvld, mrdy, bad, spill;
	wire [31:0]  fadr;
	wire [255:0] mdat, uins;
	wire [7:0]   vld, exe;
	wire [1:0]   circ, lng, xs;
	wire [29:0]  ofs;
	wire [3:0]   sz;
	integer      error_cnt = 0, compares = 0, cyc = 0, spl = 0;
	reg  [16:0]  q[$]; // Issues seen: bad, valid, exec
	vpd_dispatch u_vpd_dispatch (.core_clk_i(clk), .reset_n_i(rst_n), .fetch_req_o(freq),
		.fetch_addr_o(fadr), .mem_vld_i(mvld), .mem_data_i(mdat), .mem_rdy_o(mrdy),
		.units_rdy_i(urdy), .cond_nz_i(nz), .unit_vld_o(vld), .unit_exec_o(exe),
		.unit_ins_o(uins), .adr_circ_o(circ), .adr_long_o(lng), .adr_ofs_o(ofs),
		.adr_size_o(sz), .adr_xside_o(xs), .pkt_bad_o(bad), .pkt_spill_o(spill));
	vpd_mem_model u_mem (.clk_i(clk), .rst_n_i(rst_n), .req_i(freq), .lat_i(lat), .pk_i(pk),
		.rdy_i(mrdy), .vld_o(mvld), .data_o(mdat));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Log issues once settled; cut a hang short
	always @(negedge clk) begin
		cyc = cyc + 1;
		if (rst_n && (vld != 8'h0 || bad !== 1'b0)) q.push_back({bad, vld, exe});
		if (rst_n && spill === 1'b1) spl = spl + 1;
		if (cyc == 2000) begin
			error_cnt = error_cnt + 1;
			give_verdict;
		end
	end
	function [31:0] ins(input [2:0] u, input c, input [31:0] f);
		ins = f | {28'h0, u, c};
	endfunction
	task chk(input [255:0] got, input [255:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Hand one packet to the next fetch, wait for the fetch after it
	task run(input [255:0] p, input [3:0] n);
		integer i;
		for (i = 0; i < 300 && freq !== 1'b1; i = i + 1) @(negedge clk);
		pk = p;
		q.delete();
		@(negedge clk);
		for (i = 0; i < 300 && freq !== 1'b1; i = i + 1) @(negedge clk);
		chk(q.size(), n);
	endtask
	task t_chain;
		reg [255:0] p;
		integer k;
		for (k = 0; k < 8; k = k + 1) p[32*k+:32] = ins(k[2:0], k == 0, 32'h0);
		lat = 4'h1;
		run(p, 4'h7);
		chk(q[0], {1'b0, 8'h03, 8'h03});
		for (k = 1; k < 7; k = k + 1) chk(q[k], {1'b0, 8'h02 << k, 8'h02 << k});
		$display("chain test done");
	endtask
	task t_full;
		reg [255:0] p, e;
		integer k;
		for (k = 0; k < 8; k = k + 1) p[32*k+:32] = ins(3'h7 - k[2:0], k != 7, k << 12);
		for (k = 0; k < 8; k = k + 1) e[32*k+:32] = p[32*(7-k)+:32];
		lat = 4'h6;
		run(p, 4'h1);
		chk(q[0], {1'b0, 8'hff, 8'hff});
		chk(uins, e);
		$display("full test done");
	endtask
	task t_bad;
		reg [255:0] p;
		p = {ins(2, 0, 32'h400), ins(1, 0, 32'h20), ins(0, 1, 32'h20), ins(3, 0, 32'h10),
			ins(1, 1, 32'h10), ins(0, 0, 32'h400), ins(0, 0, 32'h0), ins(0, 1, 32'h0)};
		urdy = 1'b0;
		fork
			begin
				repeat (20) @(negedge clk);
				urdy = 1'b1;
			end
		join_none
		run(p, 4'h5);
		chk(q[0], 17'h10000);
		chk(q[1], 17'h10000);
		chk({q[2], q[3]}, {2{17'h10000}});
		chk(q[4], {1'b0, 8'h04, 8'h04});
		$display("bad test done");
	endtask
	task t_cond;
		integer k;
		nz = 5'h01;
		run({ins(7, 0, 32'hb0000000), ins(6, 0, 32'hb0000000), ins(5, 0, 32'hb0000000),
			ins(4, 0, 32'hb0000000), ins(5, 0, 32'hc0000000), ins(4, 1, 32'h40000000),
			ins(1, 1, 32'h30000000), ins(0, 1, 32'h20000000)}, 4'h5);
		chk(q[0], {1'b0, 8'h33, 8'h21});
		for (k = 1; k < 5; k = k + 1) chk(q[k], {1'b0, 8'h08 << k, 8'h08 << k});
		$display("cond test done");
	endtask
	task t_addr;
		run({ins(6, 0, 0), ins(5, 0, 0), ins(4, 0, 0), ins(2, 0, 0), ins(1, 0, 0), ins(0, 0, 0),
			ins(7, 0, 32'h07fff100), ins(3, 1, 32'h05a5aac0)}, 4'h7);
		chk({circ, lng, ofs}, {4'h5, 15'h001f, 15'h5a5a});
		chk(sz, 4'h6);
		chk(xs, 2'h1);
		$display("addr test done");
	endtask
	task t_spill;
		reg [255:0] p;
		integer k;
		// Slot 7 left chained on purpose: a supplier fault the device must flag
		for (k = 0; k < 8; k = k + 1) p[32*k+:32] = ins(k[2:0], k == 7, 32'h0);
		spl = 0;
		run(p, 4'h8);
		chk(spl, 1);
		chk(q[7], {1'b0, 8'h80, 8'h80});
		chk(fadr, 32'h0000_00c0);
		$display("spill test done");
	endtask
	task give_verdict;
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		urdy = 1'b1;
		nz = 5'h0;
		lat = 4'h2;
		pk = 256'h0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		t_chain;
		t_full;
		t_bad;
		t_cond;
		t_addr;
		t_spill;
		give_verdict;
	end
endmodule
bind vpd_dispatch vpd_chk u_chk (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
	.fetch_req_o(fetch_req_o), .fetch_addr_o(fetch_addr_o), .mem_vld_i(mem_vld_i),
	.mem_rdy_o(mem_rdy_o), .units_rdy_i(units_rdy_i), .unit_vld_o(unit_vld_o),
	.unit_exec_o(unit_exec_o), .pkt_bad_o(pkt_bad_o));
